/* File: pci_pkg.sv */
// constants shared by the pin change interrupt unit
package pci_pkg;
  // ****************************************
  // port geometry
  // ****************************************
  localparam int PCI_NUM_PORTS = 3;
  localparam int PCI_PORT_W    = 8;
  localparam int PCI_PIN_W     = PCI_NUM_PORTS * PCI_PORT_W;
  localparam int PCI_SYNC_W    = 2;
  // implemented pins per port: a = 5..0, b = 7..4, c = 7..0
  localparam logic [PCI_PIN_W-1:0] PCI_IMPL_MASK = 24'hFFF03F;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [PCI_PIN_W-1:0] PCI_ENABLE_RST = 24'h000000;
  localparam logic [PCI_PIN_W-1:0] PCI_FLAG_RST   = 24'h000000;

  // ****************************************
  // write port selector
  // ****************************************
  localparam logic [1:0] PCI_SEL_A = 2'h0;
  localparam logic [1:0] PCI_SEL_B = 2'h1;
  localparam logic [1:0] PCI_SEL_C = 2'h2;

  typedef enum logic [1:0] {
    PCI_ST_AWAKE  = 2'b01,
    PCI_ST_ASLEEP = 2'b10
  } pci_state_t;
endpackage : pci_pkg

/* File: pci_edge_detect.sv */
// per-pin input synchroniser and edge pulse generator
`timescale 1ns/1ps
module pci_edge_detect (
  // clock and reset
  input  wire logic                          core_clk_in,
  input  wire logic                          rst_b_in,
  input  wire logic                          clk_en_in,
  // pins
  input  wire logic [pci_pkg::PCI_PIN_W-1:0] pin_in,
  // pulses
  output logic      [pci_pkg::PCI_PIN_W-1:0] rise_pulse_out,
  output logic      [pci_pkg::PCI_PIN_W-1:0] fall_pulse_out
);
  import pci_pkg::*;

  logic [PCI_PIN_W-1:0] sync_meta;
  logic [PCI_PIN_W-1:0] sync_level;
  logic [PCI_PIN_W-1:0] prev_level;
  logic [PCI_SYNC_W:0]  prime_sh;
  logic                 primed;

  // ****************************************
  // synchronise, then compare with last sample
  // ****************************************
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      sync_meta  <= '0;
      sync_level <= '0;
      prev_level <= '0;
      prime_sh   <= '0;
    end else if (clk_en_in) begin
      sync_meta  <= pin_in;
      sync_level <= sync_meta;
      prev_level <= sync_level;
      prime_sh   <= {prime_sh[PCI_SYNC_W-1:0], 1'b1};
    end
  end

  // both compare stages hold real pin samples only after three enabled edges;
  // a pin edge before the first enabled edge is dropped, the price of no fake edge
  assign primed = prime_sh[PCI_SYNC_W];

  // no pulses until the pipeline holds real samples, avoids a fake edge after reset
  always_comb begin
    rise_pulse_out = (primed && clk_en_in) ? (sync_level & ~prev_level) : '0;
    fall_pulse_out = (primed && clk_en_in) ? (~sync_level & prev_level) : '0;
  end
endmodule : pci_edge_detect

/* File: pci_top.sv */
// pin change interrupt unit: enables, sticky flags, summary and request
`timescale 1ns/1ps
module pci_top (
  // clock and reset
  input  wire logic                           core_clk_in,
  input  wire logic                           rst_b_in,
  input  wire logic                           clk_en_in,
  // pins
  input  wire logic [pci_pkg::PCI_PIN_W-1:0]  pin_in,
  // register writes
  input  wire logic [1:0]                     port_sel_in,
  input  wire logic [pci_pkg::PCI_PORT_W-1:0] wr_data_in,
  input  wire logic                           rise_en_wr_in,
  input  wire logic                           fall_en_wr_in,
  input  wire logic                           flag_wr_in,
  input  wire logic                           master_en_wr_in,
  input  wire logic                           master_en_data_in,
  // sleep control
  input  wire logic                           sleep_req_in,
  // status
  output logic      [pci_pkg::PCI_PIN_W-1:0]  rise_detect_enable_out,
  output logic      [pci_pkg::PCI_PIN_W-1:0]  fall_detect_enable_out,
  output logic      [pci_pkg::PCI_PIN_W-1:0]  per_pin_change_flag_out,
  output logic                                change_irq_master_enable_out,
  output logic                                change_irq_summary_flag_out,
  output logic                                irq_out,
  output logic                                wake_out,
  output logic                                asleep_out
);
  import pci_pkg::*;

  // ****************************************
  // state
  // ****************************************
  logic [PCI_PIN_W-1:0] rise_detect_enable;
  logic [PCI_PIN_W-1:0] fall_detect_enable;
  logic [PCI_PIN_W-1:0] per_pin_change_flag;
  logic                 change_irq_master_enable;
  logic                 change_irq_summary_flag;
  logic                 irq;
  logic                 wake;
  logic                 asleep;
  pci_state_t           state;

  // ****************************************
  // wires
  // ****************************************
  logic [PCI_PIN_W-1:0] rise_pulse;
  logic [PCI_PIN_W-1:0] fall_pulse;
  logic [PCI_PIN_W-1:0] edge_hit;
  logic [PCI_PIN_W-1:0] port_mask;
  logic [PCI_PIN_W-1:0] wr_wide;
  logic [PCI_PIN_W-1:0] next_rise_en;
  logic [PCI_PIN_W-1:0] next_fall_en;
  logic [PCI_PIN_W-1:0] next_flag;
  logic                 next_summary;
  logic                 any_hit;
  logic                 sel_a;
  logic                 sel_b;
  logic                 sel_c;
  logic                 master_eff;
  logic                 wake_hit;
  logic                 next_irq;
  logic                 next_wake;
  logic                 next_asleep;
  pci_state_t           next_state;

  pci_edge_detect u_edge (
    .core_clk_in    (core_clk_in),
    .rst_b_in       (rst_b_in),
    .clk_en_in      (clk_en_in),
    .pin_in         (pin_in),
    .rise_pulse_out (rise_pulse),
    .fall_pulse_out (fall_pulse)
  );

  // ****************************************
  // write decode
  // ****************************************
  assign sel_a     = (port_sel_in == PCI_SEL_A);
  assign sel_b     = (port_sel_in == PCI_SEL_B);
  assign sel_c     = (port_sel_in == PCI_SEL_C);
  // select 3 maps to no port, so a stray write touches nothing
  assign port_mask = PCI_IMPL_MASK & {{PCI_PORT_W{sel_c}},
                                      {PCI_PORT_W{sel_b}},
                                      {PCI_PORT_W{sel_a}}};
  assign wr_wide   = {PCI_NUM_PORTS{wr_data_in}};

  // ****************************************
  // per-pin detect and flag logic
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < PCI_PIN_W; gi++) begin : g_pin
      // each pin has its own enables and flag, so any combination works
      assign edge_hit[gi] = PCI_IMPL_MASK[gi] &&
                            ((rise_pulse[gi] && rise_detect_enable[gi]) ||
                             (fall_pulse[gi] && fall_detect_enable[gi]));
      assign next_rise_en[gi] = (rise_en_wr_in && port_mask[gi]) ? wr_wide[gi]
                                                                 : rise_detect_enable[gi];
      assign next_fall_en[gi] = (fall_en_wr_in && port_mask[gi]) ? wr_wide[gi]
                                                                 : fall_detect_enable[gi];
      // the set wins over a write in the same cycle, so a masked AND loses nothing
      assign next_flag[gi] = edge_hit[gi] ? 1'b1 :
                             (flag_wr_in && port_mask[gi]) ? wr_wide[gi] :
                             per_pin_change_flag[gi];
    end
  endgenerate

  assign any_hit      = |edge_hit;
  assign next_summary = |next_flag;
  // a master write takes effect on the same edge for request and wake alike
  assign master_eff   = master_en_wr_in ? master_en_data_in : change_irq_master_enable;
  assign next_irq     = next_summary && master_eff;
  assign wake_hit     = any_hit && master_eff;

  // ****************************************
  // sleep state machine
  // ****************************************
  always_comb begin
    case (state)
      PCI_ST_AWAKE: begin
        next_state = sleep_req_in ? PCI_ST_ASLEEP : PCI_ST_AWAKE;
      end
      PCI_ST_ASLEEP: begin
        // flags settle in this same edge, so they lead the first instruction
        next_state = wake_hit ? PCI_ST_AWAKE : PCI_ST_ASLEEP;
      end
      default: begin
        next_state = PCI_ST_AWAKE;
      end
    endcase
  end

  // ****************************************
  // sleep side next values
  // ****************************************
  assign next_wake   = (state == PCI_ST_ASLEEP) && wake_hit;
  assign next_asleep = (next_state == PCI_ST_ASLEEP);

  // ****************************************
  // enable registers
  // ****************************************
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      rise_detect_enable <= PCI_ENABLE_RST;
      fall_detect_enable <= PCI_ENABLE_RST;
    end else if (clk_en_in) begin
      rise_detect_enable <= next_rise_en;
      fall_detect_enable <= next_fall_en;
    end
  end

  // ****************************************
  // sticky flags and summary
  // ****************************************
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      per_pin_change_flag     <= PCI_FLAG_RST;
      change_irq_summary_flag <= 1'b0;
    end else if (clk_en_in) begin
      // flags keep updating whatever the master enable says
      per_pin_change_flag     <= next_flag;
      change_irq_summary_flag <= next_summary;
    end
  end

  // ****************************************
  // master enable and request
  // ****************************************
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      change_irq_master_enable <= 1'b0;
      irq                      <= 1'b0;
    end else if (clk_en_in) begin
      change_irq_master_enable <= master_eff;
      // request follows the flags, held off by the master enable
      irq                      <= next_irq;
    end
  end

  // ****************************************
  // sleep state and wake pulse
  // ****************************************
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      state  <= PCI_ST_AWAKE;
      asleep <= 1'b0;
      wake   <= 1'b0;
    end else if (clk_en_in) begin
      state  <= next_state;
      asleep <= next_asleep;
      wake   <= next_wake;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign rise_detect_enable_out       = rise_detect_enable;
  assign fall_detect_enable_out       = fall_detect_enable;
  assign per_pin_change_flag_out      = per_pin_change_flag;
  assign change_irq_master_enable_out = change_irq_master_enable;
  assign change_irq_summary_flag_out  = change_irq_summary_flag;
  assign irq_out                      = irq;
  assign wake_out                     = wake;
  assign asleep_out                   = asleep;
endmodule : pci_top

/* File: pci_top_properties.sv */
// assertion checker for the pin change unit
`timescale 1ns/1ps
module pci_top_properties import pci_pkg::*; (
  input wire logic                 core_clk_in,
  input wire logic                 rst_b_in,
  input wire logic                 clk_en_in,
  input wire logic [PCI_PIN_W-1:0] pin_in,
  input wire logic                 flag_wr_in,
  input wire logic                 master_en_wr_in,
  input wire logic                 sleep_req_in,
  input wire logic [PCI_PIN_W-1:0] rise_detect_enable_out,
  input wire logic [PCI_PIN_W-1:0] fall_detect_enable_out,
  input wire logic [PCI_PIN_W-1:0] per_pin_change_flag_out,
  input wire logic                 change_irq_master_enable_out,
  input wire logic                 change_irq_summary_flag_out,
  input wire logic                 irq_out,
  input wire logic                 wake_out,
  input wire logic                 asleep_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  a_reset_clears_all: assert property ($rose(rst_b_in) |-> per_pin_change_flag_out == '0
    && rise_detect_enable_out == '0 && fall_detect_enable_out == '0 && !irq_out)
    else $error("state not cleared by reset");
  a_irq_needs_master: assert property (irq_out |-> change_irq_master_enable_out)
    else $error("request without master enable");
  a_irq_follows_flags: assert property (irq_out == (change_irq_master_enable_out
    && change_irq_summary_flag_out)) else $error("request does not follow flags");
  a_summary_is_or: assert property (change_irq_summary_flag_out == |per_pin_change_flag_out)
    else $error("summary differs from flags");
  a_unimpl_read_zero: assert property (((rise_detect_enable_out | fall_detect_enable_out
    | per_pin_change_flag_out) & ~PCI_IMPL_MASK) == '0) else $error("absent pin bit set");
  a_flag_needs_cause: assert property (|(per_pin_change_flag_out & ~$past(per_pin_change_flag_out)
    & ~($past(pin_in, 3) ^ $past(pin_in, 4))) |-> $past(flag_wr_in))
    else $error("flag set without edge");
  a_flag_only_cleared: assert property (|($past(per_pin_change_flag_out)
    & ~per_pin_change_flag_out) |-> $past(flag_wr_in)) else $error("flag lost");
  a_sleep_entry: assert property (sleep_req_in && !asleep_out && clk_en_in |=> asleep_out)
    else $error("sleep not entered");
  a_wake_cause: assert property (wake_out && $past(clk_en_in) |-> $past(asleep_out) && !asleep_out
    && change_irq_master_enable_out && change_irq_summary_flag_out) else $error("bad wake");
  a_stay_asleep_off: assert property (asleep_out && !change_irq_master_enable_out
    && !master_en_wr_in |=> asleep_out) else $error("woke with master off");
  c_wake: cover property (wake_out);
  c_irq: cover property ($rose(irq_out));
  c_clear: cover property ($fell(change_irq_summary_flag_out));
endmodule : pci_top_properties

bind pci_top pci_top_properties chk (.*);

/* File: pci_pin_model.sv */
// external port signals driven at the pins
`timescale 1ns/1ps
module pci_pin_model import pci_pkg::*; (
  input  wire logic                 core_clk_in,
  input  wire logic [PCI_PIN_W-1:0] level_in,
  output logic      [PCI_PIN_W-1:0] pin_out
);
  initial pin_out = '0;
  // pins move well away from the edge, like an unrelated source
  always @(posedge core_clk_in) pin_out <= #3 level_in;
endmodule : pci_pin_model

/* File: tb_pin_change_interrupt.sv */
// self-checking bench for the pin change unit
`timescale 1ns/1ps
module tb_pin_change_interrupt;
  import pci_pkg::*;
  logic core_clk_in = 0, rst_b_in = 0, flag_wr_in = 0, rise_en_wr_in = 0, fall_en_wr_in = 0;
  logic master_en_wr_in = 0, master_en_data_in = 0, sleep_req_in = 0, em = 0;
  logic clk_en_in = 1;
  logic [1:0] port_sel_in = 0;
  logic [7:0] wr_data_in = 0;
  logic [PCI_PIN_W-1:0] level = 0, old, pins, rise, fall, flags, er = 0, ef = 0, efl = 0;
  logic master, summ, irq, wake, asleep;
  logic [15:0] lfsr = 16'hD14B;
  int errors = 0, n_compared = 0;
  always #5 core_clk_in = ~core_clk_in;
  pci_pin_model pm (.core_clk_in, .level_in(level), .pin_out(pins));
  pci_top dut (.core_clk_in, .rst_b_in, .clk_en_in, .pin_in(pins), .port_sel_in,
    .wr_data_in, .rise_en_wr_in, .fall_en_wr_in, .flag_wr_in, .master_en_wr_in,
    .master_en_data_in, .sleep_req_in, .rise_detect_enable_out(rise),
    .fall_detect_enable_out(fall), .per_pin_change_flag_out(flags),
    .change_irq_master_enable_out(master), .change_irq_summary_flag_out(summ),
    .irq_out(irq), .wake_out(wake), .asleep_out(asleep));
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd
  function automatic logic [PCI_PIN_W-1:0] hits(input logic [PCI_PIN_W-1:0] a, b);
    return ((er & b & ~a) | (ef & a & ~b)) & PCI_IMPL_MASK;
  endfunction : hits
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : tick
  task automatic cmp(input logic [PCI_PIN_W-1:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  // kind 0 rise enables, 1 fall enables, 2 flags; port 3 selects nothing
  task automatic wr(input int kind, input int p, input logic [7:0] d);
    port_sel_in = p[1:0];
    wr_data_in = d;
    rise_en_wr_in = (kind == 0);
    fall_en_wr_in = (kind == 1);
    flag_wr_in = (kind == 2);
    if (p < 3 && kind == 0) er[p*8 +: 8] = d & PCI_IMPL_MASK[p*8 +: 8];
    if (p < 3 && kind == 1) ef[p*8 +: 8] = d & PCI_IMPL_MASK[p*8 +: 8];
    if (p < 3 && kind == 2) efl[p*8 +: 8] = d & PCI_IMPL_MASK[p*8 +: 8];
    tick(1);
    {rise_en_wr_in, fall_en_wr_in, flag_wr_in} = 3'h0;
    tick(1);
  endtask : wr
  task automatic setm(input logic v);
    master_en_wr_in = 1;
    master_en_data_in = v;
    em = v;
    tick(1);
    master_en_wr_in = 0;
  endtask : setm
  task automatic flip(input int n);
    old = level;
    level[0] = ~level[0];
    efl |= hits(old, level);
    tick(n);
  endtask : flip
  task automatic close_out();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  initial begin
    tick(6);
    rst_b_in = 1;
    tick(3);
    cmp(flags | rise | fall, '0);
    for (int i = 0; i < 48; i++) begin
      if (i % 8 == 0) for (int p = 0; p < 4; p++) wr(p % 2, p, 8'(rnd()));
      if (i % 8 == 0) for (int p = 0; p < 4; p++) wr(1 - p % 2, p, 8'(rnd()));
      if (i % 8 == 0) cmp(rise, er);
      if (i % 8 == 0) cmp(fall, ef);
      setm(1'(rnd()));
      cmp(master, em);
      old = level;
      level = 24'({rnd(), rnd()});
      efl |= hits(old, level);
      tick(5);
      cmp(flags, efl);
      cmp(summ, |efl);
      cmp(irq, em & |efl);
      wr(2, i % 3, efl[(i % 3)*8 +: 8] & 8'(rnd()));
      cmp(flags, efl);
    end
    wr(0, 0, 8'h01);
    wr(1, 0, 8'h01);
    flip(3);
    wr(2, 0, 8'h00);
    cmp(flags[7:0], 8'h01);
    wr(2, 0, 8'h00);
    cmp(flags[7:0], 8'h00);
    clk_en_in = 0;
    {flag_wr_in, sleep_req_in, wr_data_in, port_sel_in} = {2'h3, 8'hFF, 2'h0};
    tick(2);
    {flag_wr_in, sleep_req_in, clk_en_in} = 3'h1;
    tick(1);
    cmp({flags[7:0], asleep}, 9'h000);
    setm(1);
    sleep_req_in = 1;
    tick(2);
    sleep_req_in = 0;
    cmp(asleep, 1);
    flip(4);
    cmp({asleep, flags[0], wake, irq}, 4'h7);
    tick(1);
    cmp(wake, 0);
    wr(2, 0, 8'h00);
    setm(0);
    sleep_req_in = 1;
    tick(2);
    sleep_req_in = 0;
    flip(5);
    cmp({asleep, flags[0], irq}, 3'h6);
    rst_b_in = 0;
    tick(2);
    rst_b_in = 1;
    tick(1);
    cmp(flags | rise | fall, '0);
    cmp({asleep, irq, wake, summ, master}, '0);
    close_out();
  end
  initial begin
    #100000;
    errors++;
    close_out();
  end
endmodule : tb_pin_change_interrupt
